// ---- hw/ssg_cfg.svh ----
// register offsets, field positions, reset values and timing counts
`ifndef SSG_CFG_SVH
`define SSG_CFG_SVH

// ****************************************************************
// register word offsets (byte address is the offset times 4)
// ****************************************************************
`define SSG_ADDR_CTRL 6'h00
`define SSG_ADDR_CMD 6'h01
`define SSG_ADDR_JOG 6'h02
`define SSG_ADDR_SHIFT_T 6'h03
`define SSG_ADDR_SHIFT_V 6'h04
`define SSG_ADDR_MAX12 6'h05
`define SSG_ADDR_MAX34 6'h06
`define SSG_ADDR_SPEED 6'h07
`define SSG_ADDR_STATUS 6'h08

// ****************************************************************
// control register fields
// ****************************************************************
`define SSG_CTRL_CHUCK_OFF 0
`define SSG_CTRL_TAIL_OFF 1
`define SSG_CTRL_STYLE 2
`define SSG_CTRL_VARFREQ 3
`define SSG_CTRL_CODEMODE 4
`define SSG_CTRL_INPOS 5
`define SSG_CTRL_LINES_LO 8
`define SSG_LINES_RESET 3'h4

// ****************************************************************
// command register fields
// ****************************************************************
`define SSG_CMD_KEY_CW 0
`define SSG_CMD_KEY_STOP 1
`define SSG_CMD_TYPED_CW 2
`define SSG_CMD_TYPED_CCW 3
`define SSG_CMD_TYPED_STOP 4
`define SSG_CMD_CHUCK 5
`define SSG_CMD_TAIL 6
`define SSG_CMD_GEAR 7
`define SSG_CMD_GEAR_LO 8
`define SSG_CMD_ALM_CLR 12

// ****************************************************************
// timing
// ****************************************************************
`define SSG_CLOCK_HZ 25000000
`define SSG_TICK_MS 1
`define SSG_TICK_CYCLES (`SSG_CLOCK_HZ / 1000 * `SSG_TICK_MS)
`define SSG_PULSE_MS 50
`define SSG_PULSE_TICKS (`SSG_PULSE_MS / `SSG_TICK_MS)

`endif

// ---- hw/ssg_pkg.sv ----
// types of the spindle run and gear sequencer
package ssg_pkg;

  typedef logic [13:0] ssg_mv_type;

  typedef enum logic [1:0] {
    SP_STOP = 2'b00,
    SP_CW = 2'b01,
    SP_CCW = 2'b10,
    SP_JOG = 2'b11
  } ssg_spin_type;

  typedef enum logic [2:0] {
    SH_IDLE = 3'b000,
    SH_DROP = 3'b001,
    SH_GAP = 3'b010,
    SH_WAIT = 3'b011,
    SH_SETTLE = 3'b100
  } ssg_shift_type;

  typedef enum logic [1:0] {
    PL_CW = 2'b00,
    PL_CCW = 2'b01,
    PL_STOP = 2'b10
  } ssg_pulse_type;

  typedef struct packed {
    logic [2:0] lineCount;
    logic inPosUsed;
    logic codeMode;
    logic varFreq;
    logic styleSel;
    logic tailOff;
    logic chuckOff;
  } ssg_ctrl_type;

  typedef struct packed {
    logic apValid;
    logic apWrite;
    logic [5:0] apAddr;
    logic [31:0] rdata;
    ssg_ctrl_type ctrl;
    logic [15:0] jogTime;
    ssg_mv_type jogSpeed;
    logic [7:0] dlyFirst;
    logic [7:0] dlyGap;
    logic [7:0] dlySecond;
    ssg_mv_type shiftMv;
    ssg_mv_type [3:0] maxMv;
    ssg_mv_type analog;
    logic [15:0] tick;
    ssg_spin_type spin;
    logic jogMode;
    logic [15:0] jogCnt;
    logic [7:0] pulseCnt;
    ssg_pulse_type pulseSel;
    ssg_shift_type shift;
    logic [7:0] shiftCnt;
    logic [1:0] curGear;
    logic [1:0] newGear;
    logic [3:0] gearDrive;
    logic [3:0] codeGear;
    logic chuckAlm;
    logic tailAlm;
    logic chuckGo;
    logic tailGo;
    logic started;
  } ssg_state_type;

endpackage

// ---- hw/ssg_spindle_gear.sv ----
// spindle run/stop/jog control with gear line sequencer, AHB-Lite slave
// What this block does and what it expects of the gearbox
// [R1] clockwise command starts spindle and lights indicator; stop command stops it
// [R2] stop key while stopped toggles between normal and jog state
// [R3] jog clockwise runs at jog speed for jog time; stop key ends early
// [R4] typed run, reverse and stop commands are ignored in jog state
// [R5] jog run time of zero disables jog entirely
// [R6] chuck interlock: no start while clamped, no chuck while turning; alarms
// [R7] tailstock interlock: no tailstock operation while turning; alarm
// [R8] output style selects level or pulse run and stop outputs; brake output always pulses
// [R9] fixed-speed spindle: two-digit speed word is a gear number
// [R10] only the configured count of gear lines is driven, from line 1
// [R11] bit mode: gear 1 to 4 lights one line, gear 0 none
// [R12] code mode: gear 0 to 15 as binary, line 1 least significant
// [R13] code mode with fewer lines drives only the low code bits
// [R14] gear lines off at power-on; selecting one cancels the others
// [R15] variable-frequency spindle: each gear command owns one gear line
// [R16] power-on: no memory gives gear 1 undriven, memory restores old gear
// [R17] gear change skipped when requested gear equals current gear
// [R18] first shift step outputs the shift voltage in millivolts
// [R19] after first delay drop old line, after interval raise new line
// [R20] optionally wait without limit for the new gear in-position input
// [R21] gearbox raises the gear in-position input when the change completes
// [R22] after second delay output new gear maximum speed and finish
`timescale 1ns/1ps
`include "ssg_cfg.svh"

module ssg_spindle_gear #(
  parameter int TICK_CYCLES = `SSG_TICK_CYCLES,
  parameter int PULSE_TICKS = `SSG_PULSE_TICKS
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic chuckClamped,
  input wire logic [3:0] gearInPos,
  input wire logic gearMemoryEnable,
  input wire logic [1:0] retainedGear,
  output logic spinCw,
  output logic spinCcw,
  output logic spinStop,
  output logic spindleBrakeOut,
  output logic spinIndicator,
  output logic jogActive,
  output logic chuckGo,
  output logic tailGo,
  output logic chuckAlarm,
  output logic tailAlarm,
  output logic [3:0] gearLines,
  output logic [3:0] gearLineOe,
  output ssg_pkg::ssg_mv_type analogMv,
  output logic [1:0] currentGear,
  output logic shiftBusy
);
  import ssg_pkg::*;

  // ****************************************************************
  // functions
  // ****************************************************************
  function automatic logic [3:0] lineMask(input logic [2:0] cnt);
    lineMask = (cnt >= 3'h4) ? 4'hf : ((4'h1 << cnt) - 4'h1);
  endfunction

  function automatic logic [3:0] oneHot(input logic [3:0] g);
    oneHot = (g == 4'h0 || g > 4'h4) ? 4'h0 : (4'h1 << (g - 4'h1));
  endfunction

  // ****************************************************************
  // state and decode
  // ****************************************************************
  ssg_state_type s_q;
  ssg_state_type s_d;
  logic wrEn;
  logic cmdWr;
  logic tickNow;
  logic running;
  logic pulseOn;
  logic [3:0] gearVal;
  logic [31:0] rdVal;
  logic startReq;
  logic stopReq;
  ssg_spin_type startDir;

  assign wrEn = s_q.apValid && s_q.apWrite;
  assign cmdWr = wrEn && s_q.apAddr == `SSG_ADDR_CMD;
  assign tickNow = s_q.tick == 16'(TICK_CYCLES - 1);
  assign running = s_q.spin != SP_STOP;
  assign pulseOn = s_q.pulseCnt != 8'h0;
  assign gearVal = hwdata[`SSG_CMD_GEAR_LO +: 4];

  always_comb begin
    case (haddr[7:2])
      `SSG_ADDR_CTRL: rdVal = {21'h0, s_q.ctrl[8:6], 2'h0, s_q.ctrl[5:0]};
      `SSG_ADDR_JOG: rdVal = {2'h0, s_q.jogSpeed, s_q.jogTime};
      `SSG_ADDR_SHIFT_T: rdVal = {8'h0, s_q.dlySecond, s_q.dlyGap,
                                  s_q.dlyFirst};
      `SSG_ADDR_SHIFT_V: rdVal = {18'h0, s_q.shiftMv};
      `SSG_ADDR_MAX12: rdVal = {2'h0, s_q.maxMv[1], 2'h0, s_q.maxMv[0]};
      `SSG_ADDR_MAX34: rdVal = {2'h0, s_q.maxMv[3], 2'h0, s_q.maxMv[2]};
      `SSG_ADDR_SPEED: rdVal = {18'h0, s_q.analog};
      `SSG_ADDR_STATUS: rdVal = {2'h0, analogMv, gearLines, 2'h0,
                                 s_q.curGear, 1'b0, s_q.tailAlm, s_q.chuckAlm,
                                 shiftBusy, s_q.jogMode, spinIndicator,
                                 s_q.spin == SP_CCW, spinCw};
      default: rdVal = 32'h0;
    endcase
  end

  // run requests: typed commands only outside jog state
  always_comb begin
    startReq = 1'b0;
    startDir = SP_CW;
    stopReq = 1'b0;
    if (cmdWr) begin
      if (hwdata[`SSG_CMD_KEY_STOP] && running) begin
        stopReq = 1'b1; // [R1] [R3]
      end
      if (hwdata[`SSG_CMD_TYPED_STOP] && !s_q.jogMode) begin
        stopReq = 1'b1; // [R4]
      end
      if (hwdata[`SSG_CMD_KEY_CW] && s_q.jogMode) begin
        startReq = s_q.spin == SP_STOP && s_q.jogTime != 16'h0;
        startDir = SP_JOG; // [R3] [R5]
      end else if (!s_q.jogMode) begin
        if (hwdata[`SSG_CMD_KEY_CW] || hwdata[`SSG_CMD_TYPED_CW]) begin
          startReq = 1'b1; // [R1]
        end else if (hwdata[`SSG_CMD_TYPED_CCW]) begin
          startReq = 1'b1;
          startDir = SP_CCW;
        end
      end
    end
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    s_d = s_q;
    s_d.chuckGo = 1'b0;
    s_d.tailGo = 1'b0;
    s_d.tick = tickNow ? 16'h0 : s_q.tick + 16'h1;
    // bus address phase, zero wait states
    if (hready) begin
      s_d.apValid = hsel && htrans[1];
      s_d.apWrite = hwrite;
      s_d.apAddr = haddr[7:2];
      s_d.rdata = (hsel && htrans[1] && !hwrite) ? rdVal : 32'h0;
    end
    if (wrEn) begin
      case (s_q.apAddr)
        `SSG_ADDR_CTRL: begin
          s_d.ctrl.chuckOff = hwdata[`SSG_CTRL_CHUCK_OFF];
          s_d.ctrl.tailOff = hwdata[`SSG_CTRL_TAIL_OFF];
          s_d.ctrl.styleSel = hwdata[`SSG_CTRL_STYLE];
          s_d.ctrl.varFreq = hwdata[`SSG_CTRL_VARFREQ];
          s_d.ctrl.codeMode = hwdata[`SSG_CTRL_CODEMODE];
          s_d.ctrl.inPosUsed = hwdata[`SSG_CTRL_INPOS];
          s_d.ctrl.lineCount = hwdata[`SSG_CTRL_LINES_LO +: 3];
        end
        `SSG_ADDR_JOG: begin
          s_d.jogTime = hwdata[15:0];
          s_d.jogSpeed = hwdata[29:16];
        end
        `SSG_ADDR_SHIFT_T: begin
          s_d.dlyFirst = hwdata[7:0];
          s_d.dlyGap = hwdata[15:8];
          s_d.dlySecond = hwdata[23:16];
        end
        `SSG_ADDR_SHIFT_V: s_d.shiftMv = hwdata[13:0];
        `SSG_ADDR_MAX12: begin
          s_d.maxMv[0] = hwdata[13:0];
          s_d.maxMv[1] = hwdata[29:16];
        end
        `SSG_ADDR_MAX34: begin
          s_d.maxMv[2] = hwdata[13:0];
          s_d.maxMv[3] = hwdata[29:16];
        end
        `SSG_ADDR_SPEED: s_d.analog = hwdata[13:0];
        default: ;
      endcase
    end
    // output pulse timer
    if (pulseOn && tickNow) begin
      s_d.pulseCnt = s_q.pulseCnt - 8'h1; // [R8]
    end
    // jog run timeout
    if (s_q.spin == SP_JOG && tickNow) begin
      if (s_q.jogCnt <= 16'h1) begin
        s_d.spin = SP_STOP; // [R3]
        s_d.pulseCnt = 8'(PULSE_TICKS);
        s_d.pulseSel = PL_STOP;
      end else begin
        s_d.jogCnt = s_q.jogCnt - 16'h1;
      end
    end
    // alarms clear first so a refusal in the same cycle wins
    if (cmdWr && hwdata[`SSG_CMD_ALM_CLR]) begin
      s_d.chuckAlm = 1'b0;
      s_d.tailAlm = 1'b0;
    end
    if (stopReq) begin
      s_d.spin = SP_STOP; // [R1]
      s_d.pulseCnt = 8'(PULSE_TICKS);
      s_d.pulseSel = PL_STOP;
    end else if (startReq) begin
      if (!s_q.ctrl.chuckOff && chuckClamped) begin
        s_d.chuckAlm = 1'b1; // [R6]
      end else begin
        s_d.spin = startDir; // [R1] [R3]
        s_d.jogCnt = s_q.jogTime;
        s_d.pulseCnt = 8'(PULSE_TICKS);
        s_d.pulseSel = (startDir == SP_CCW) ? PL_CCW : PL_CW;
      end
    end else if (cmdWr && hwdata[`SSG_CMD_KEY_STOP] && !running &&
                 s_q.jogTime != 16'h0) begin
      s_d.jogMode = !s_q.jogMode; // [R2]
    end
    if (s_q.jogTime == 16'h0) begin
      s_d.jogMode = 1'b0; // [R5]
    end
    // chuck and tailstock interlocks
    if (cmdWr && hwdata[`SSG_CMD_CHUCK]) begin
      if (!s_q.ctrl.chuckOff && running) begin
        s_d.chuckAlm = 1'b1; // [R6]
      end else begin
        s_d.chuckGo = 1'b1;
      end
    end
    if (cmdWr && hwdata[`SSG_CMD_TAIL]) begin
      if (!s_q.ctrl.tailOff && running) begin
        s_d.tailAlm = 1'b1; // [R7]
      end else begin
        s_d.tailGo = 1'b1;
      end
    end
    // gear commands
    if (cmdWr && hwdata[`SSG_CMD_GEAR]) begin
      if (!s_q.ctrl.varFreq) begin
        if (s_q.ctrl.codeMode || gearVal <= 4'h4) begin
          s_d.codeGear = gearVal; // [R9] [R11] [R12]
        end
      end else if (s_q.shift == SH_IDLE && gearVal != 4'h0 &&
                   gearVal <= 4'h4 &&
                   2'(gearVal - 4'h1) != s_q.curGear) begin
        s_d.newGear = 2'(gearVal - 4'h1); // [R15] [R17]
        s_d.analog = s_q.shiftMv; // [R18]
        s_d.shiftCnt = s_q.dlyFirst;
        s_d.shift = SH_DROP;
      end
    end
    if (s_q.shiftCnt != 8'h0 && tickNow) begin
      s_d.shiftCnt = s_q.shiftCnt - 8'h1;
    end
    case (s_q.shift)
      SH_IDLE: ;
      SH_DROP: begin
        if (s_q.shiftCnt == 8'h0) begin
          s_d.gearDrive = 4'h0; // [R19]
          s_d.shiftCnt = s_q.dlyGap;
          s_d.shift = SH_GAP;
        end
      end
      SH_GAP: begin
        if (s_q.shiftCnt == 8'h0) begin
          s_d.gearDrive = 4'h1 << s_q.newGear; // [R19] [R14]
          s_d.curGear = s_q.newGear;
          s_d.shift = SH_WAIT;
        end
      end
      SH_WAIT: begin
        if (!s_q.ctrl.inPosUsed || gearInPos[s_q.newGear]) begin
          s_d.shiftCnt = s_q.dlySecond; // [R20] [R21]
          s_d.shift = SH_SETTLE;
        end
      end
      SH_SETTLE: begin
        if (s_q.shiftCnt == 8'h0) begin
          s_d.analog = s_q.maxMv[s_q.curGear]; // [R22]
          s_d.shift = SH_IDLE;
        end
      end
      default: s_d.shift = SH_IDLE;
    endcase
    // gear memory is sampled on the first clock after reset release
    if (!s_q.started) begin
      s_d.started = 1'b1;
      if (gearMemoryEnable) begin
        s_d.curGear = retainedGear; // [R16]
        s_d.gearDrive = 4'h1 << retainedGear;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.ctrl.lineCount <= `SSG_LINES_RESET;
      s_q.pulseSel <= PL_STOP;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s_q.rdata;
  // level style follows the run state, pulse style the pulse timer
  assign spinCw = !s_q.ctrl.styleSel ?
    (s_q.spin == SP_CW || s_q.spin == SP_JOG) :
    (pulseOn && s_q.pulseSel == PL_CW); // [R8]
  assign spinCcw = !s_q.ctrl.styleSel ? s_q.spin == SP_CCW :
    (pulseOn && s_q.pulseSel == PL_CCW); // [R8]
  assign spinStop = !s_q.ctrl.styleSel ? !running :
    (pulseOn && s_q.pulseSel == PL_STOP); // [R8]
  assign spindleBrakeOut = pulseOn && s_q.pulseSel == PL_STOP;
  assign spinIndicator = running; // [R1] [R3]
  assign jogActive = s_q.jogMode;
  assign chuckGo = s_q.chuckGo;
  assign tailGo = s_q.tailGo;
  assign chuckAlarm = s_q.chuckAlm;
  assign tailAlarm = s_q.tailAlm;
  assign gearLineOe = lineMask(s_q.ctrl.lineCount); // [R10] [R13]
  assign gearLines = gearLineOe & (s_q.ctrl.varFreq ? s_q.gearDrive :
    (s_q.ctrl.codeMode ? s_q.codeGear : oneHot(s_q.codeGear))); // [R11]
  assign analogMv = (s_q.spin == SP_JOG) ? s_q.jogSpeed : s_q.analog;
  assign currentGear = s_q.curGear;
  assign shiftBusy = s_q.shift != SH_IDLE;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence seqShiftStart;
    cmdWr && hwdata[`SSG_CMD_GEAR] && s_q.ctrl.varFreq &&
    s_q.shift == SH_IDLE && gearVal == 4'h3 && s_q.curGear != 2'h2;
  endsequence

  sequence seqShiftGap;
    s_q.shift == SH_GAP ##1 s_q.shift == SH_WAIT;
  endsequence

  a_cw_start: assert property (cmdWr && hwdata[`SSG_CMD_TYPED_CW] && // [R1]
    !hwdata[`SSG_CMD_TYPED_STOP] && !s_q.jogMode && !running &&
    !chuckClamped |=> s_q.spin == SP_CW && spinIndicator)
    else $error("typed clockwise did not start the spindle");
  a_stop_toggle: assert property (cmdWr && !startReq && // [R2]
    hwdata[`SSG_CMD_KEY_STOP] && !running && s_q.jogTime != 16'h0 |=>
    s_q.jogMode != $past(s_q.jogMode))
    else $error("stop key did not toggle jog state");
  a_jog_end: assert property (s_q.spin == SP_JOG && // [R3]
    s_q.jogCnt == 16'h1 && tickNow |=> !spinIndicator)
    else $error("jog run did not end at its time");
  a_jog_ignore: assert property (s_q.jogMode && cmdWr && // [R4]
    !hwdata[`SSG_CMD_KEY_CW] && !hwdata[`SSG_CMD_KEY_STOP] &&
    s_q.spin == SP_STOP |=> s_q.spin == SP_STOP)
    else $error("typed command acted in jog state");
  a_jog_disabled: assert property (s_q.jogTime == 16'h0 |=> // [R5]
    !jogActive)
    else $error("jog state with zero run time");
  a_chuck_refuse: assert property (startReq && !stopReq && // [R6]
    !s_q.ctrl.chuckOff && chuckClamped |=> chuckAlarm &&
    $stable(s_q.spin))
    else $error("start not refused while chuck clamped");
  a_tail_refuse: assert property (cmdWr && hwdata[`SSG_CMD_TAIL] && // [R7]
    !s_q.ctrl.tailOff && running |=> tailAlarm && !tailGo)
    else $error("tailstock not refused while turning");
  a_line_mask: assert property ((gearLines & ~gearLineOe) == 4'h0 && // [R10]
    (s_q.ctrl.codeMode || s_q.ctrl.varFreq ||
     $countones(gearLines) <= 1))
    else $error("gear line outside the configured count");
  a_skip_same: assert property (cmdWr && hwdata[`SSG_CMD_GEAR] && // [R17]
    s_q.ctrl.varFreq && s_q.shift == SH_IDLE &&
    2'(gearVal - 4'h1) == s_q.curGear |=> !shiftBusy)
    else $error("gear change ran for the current gear");
  a_shift_volt: assert property (seqShiftStart |=> // [R18]
    s_q.analog == $past(s_q.shiftMv) && s_q.shift == SH_DROP)
    else $error("shift voltage not output at start");
  a_new_line: assert property (seqShiftGap |-> ##0 // [R19]
    s_q.gearDrive == (4'h1 << s_q.curGear))
    else $error("new gear line not raised after interval");
  a_wait_inpos: assert property (s_q.shift == SH_WAIT && // [R20]
    s_q.ctrl.inPosUsed && !gearInPos[s_q.newGear] |=>
    s_q.shift == SH_WAIT)
    else $error("in-position wait left early");
  a_settle_end: assert property (s_q.shift == SH_SETTLE && // [R22]
    s_q.shiftCnt == 8'h0 |=> !shiftBusy &&
    s_q.analog == s_q.maxMv[s_q.curGear])
    else $error("shift end did not set gear maximum speed");

endmodule // ssg_spindle_gear

// ---- verif/ssg_gearbox_model.sv ----
// gearbox model that raises the in-position input of the driven gear line
`timescale 1ns/1ps

module ssg_gearbox_model (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [3:0] gearLines,
  input wire logic [3:0] gearLineOe,
  input wire logic [7:0] holdCycles,
  output logic [3:0] gearInPos
);
  // ****************************************************************
  // mechanical change time after the line pattern settles
  // ****************************************************************
  logic [3:0] seen_q;
  logic [7:0] wait_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      seen_q <= 4'h0;
      wait_q <= 8'h00;
      gearInPos <= 4'h0;
    end else if ((gearLines & gearLineOe) != seen_q) begin
      seen_q <= gearLines & gearLineOe;
      wait_q <= 8'h00;
      gearInPos <= 4'h0;
    end else if (wait_q < holdCycles) begin
      wait_q <= wait_q + 8'h01;
    end else begin
      gearInPos <= seen_q;
    end
  end
endmodule // ssg_gearbox_model

// ---- verif/ssg_spindle_gear_tb.sv ----
// self-checking bench of the spindle run and gear sequencer
`timescale 1ns/1ps
`include "ssg_cfg.svh"

`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_errors++; \
  $display("BAD %0t got %h want %h", $time, a, e); end end

module ssg_spindle_gear_tb;
  import ssg_pkg::*;
  // ****************************************************************
  // stimulus, design and gearbox
  // ****************************************************************
  localparam int TICK = 4;
  localparam logic [31:0] A_CTRL = {24'h0, `SSG_ADDR_CTRL, 2'b00};
  localparam logic [31:0] A_CMD = {24'h0, `SSG_ADDR_CMD, 2'b00};
  localparam logic [31:0] A_JOG = {24'h0, `SSG_ADDR_JOG, 2'b00};
  localparam logic [31:0] A_SHT = {24'h0, `SSG_ADDR_SHIFT_T, 2'b00};
  localparam logic [31:0] A_SHV = {24'h0, `SSG_ADDR_SHIFT_V, 2'b00};
  localparam logic [31:0] A_M12 = {24'h0, `SSG_ADDR_MAX12, 2'b00};
  localparam logic [31:0] A_M34 = {24'h0, `SSG_ADDR_MAX34, 2'b00};
  localparam logic [31:0] K_KCW = 32'h1 << `SSG_CMD_KEY_CW;
  localparam logic [31:0] K_KSTOP = 32'h1 << `SSG_CMD_KEY_STOP;
  localparam logic [31:0] K_TCW = 32'h1 << `SSG_CMD_TYPED_CW;
  localparam logic [31:0] K_TCCW = 32'h1 << `SSG_CMD_TYPED_CCW;
  localparam logic [31:0] K_TSTOP = 32'h1 << `SSG_CMD_TYPED_STOP;
  localparam logic [31:0] K_CHUCK = 32'h1 << `SSG_CMD_CHUCK;
  localparam logic [31:0] K_TAIL = 32'h1 << `SSG_CMD_TAIL;
  localparam logic [31:0] K_GEAR = 32'h1 << `SSG_CMD_GEAR;
  localparam logic [31:0] K_CLR = 32'h1 << `SSG_CMD_ALM_CLR;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic chuckClamped = 1'b0;
  logic gearMemoryEnable = 1'b0;
  logic [1:0] retainedGear = 2'd0;
  logic [7:0] holdCycles = 8'd2;
  logic hreadyout, hresp, spinCw, spinCcw, spinStop, spindleBrakeOut;
  logic spinIndicator, jogActive, chuckGo, tailGo, chuckAlarm, tailAlarm;
  logic shiftBusy;
  logic [31:0] hrdata;
  logic [3:0] gearLines, gearLineOe, gearInPos;
  logic [1:0] currentGear;
  ssg_mv_type analogMv;
  int n_errors = 0;
  int checks = 0;
  int cycles = 0;
  int nGo = 0;

  ssg_spindle_gear #(.TICK_CYCLES(TICK), .PULSE_TICKS(2)) dut_u (
    .clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .chuckClamped(chuckClamped), .gearInPos(gearInPos),
    .gearMemoryEnable(gearMemoryEnable), .retainedGear(retainedGear),
    .spinCw(spinCw), .spinCcw(spinCcw), .spinStop(spinStop),
    .spindleBrakeOut(spindleBrakeOut), .spinIndicator(spinIndicator),
    .jogActive(jogActive), .chuckGo(chuckGo), .tailGo(tailGo),
    .chuckAlarm(chuckAlarm), .tailAlarm(tailAlarm), .gearLines(gearLines),
    .gearLineOe(gearLineOe), .analogMv(analogMv),
    .currentGear(currentGear), .shiftBusy(shiftBusy));

  ssg_gearbox_model gearbox_u (
    .clock(clock), .rst_n(rst_n), .gearLines(gearLines),
    .gearLineOe(gearLineOe), .holdCycles(holdCycles),
    .gearInPos(gearInPos));

  always #20 clock = ~clock;

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (chuckGo === 1'b1 || tailGo === 1'b1) begin
      nGo <= nGo + 1;
    end
    if (cycles == 20000) begin
      n_errors++;
      close_out();
    end
  end

  // ****************************************************************
  // bus cycles and helpers
  // ****************************************************************
  task automatic bus(input logic w, input logic [31:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    r = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic cmd(input logic [31:0] d);
    wr(A_CMD, d);
    repeat (3) @(posedge clock);
  endtask

  function automatic logic [31:0] gear(input logic [3:0] v);
    return K_GEAR | {20'h0, v, 8'h00};
  endfunction

  function automatic logic [31:0] ctrl(input logic [2:0] n,
                                       input logic [5:0] b);
    return {21'h0, n, 2'b00, b};
  endfunction

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    logic [31:0] r;
    `CHK(spinStop, 1'b1)
    `CHK(gearLines, 4'h0)
    `CHK(currentGear, 2'd0)
    bus(1'b0, A_CTRL, 32'h0, r);
    `CHK(r, 32'h00000400)
    bus(1'b0, 32'h00000024, 32'h0, r);
    `CHK(r, 32'h0)
    `CHK(hresp, 1'b0)
    `CHK(hreadyout, 1'b1)
  endtask

  task automatic t_run();
    cmd(K_TCW);
    `CHK(spinCw, 1'b1)
    `CHK(spinIndicator, 1'b1)
    cmd(K_TSTOP);
    `CHK(spinCw, 1'b0)
    `CHK(spinStop, 1'b1)
    cmd(K_TCCW);
    `CHK(spinCcw, 1'b1)
    cmd(K_TSTOP);
  endtask

  task automatic t_chuck();
    chuckClamped <= 1'b1;
    cmd(K_TCW);
    `CHK(spinIndicator, 1'b0)
    `CHK(chuckAlarm, 1'b1)
    chuckClamped <= 1'b0;
    cmd(K_CLR);
    `CHK(chuckAlarm, 1'b0)
    cmd(K_TCW);
    cmd(K_CHUCK | K_TAIL);
    `CHK(chuckAlarm, 1'b1)
    `CHK(tailAlarm, 1'b1)
    `CHK(nGo, 0)
    cmd(K_TSTOP | K_CLR);
    cmd(K_CHUCK);
    `CHK(nGo, 1)
    cmd(K_TAIL);
    `CHK(nGo, 2)
  endtask

  task automatic t_jog();
    wr(A_JOG, {2'b00, 14'h0320, 16'd3});
    cmd(K_KSTOP);
    `CHK(jogActive, 1'b1)
    cmd(K_TCW);
    `CHK(spinIndicator, 1'b0)
    cmd(K_TCCW);
    `CHK(spinIndicator, 1'b0)
    cmd(K_KCW);
    `CHK(spinCw, 1'b1)
    `CHK(analogMv, 14'h0320)
    cmd(K_TSTOP);
    `CHK(spinIndicator, 1'b1)
    repeat (5 * TICK) @(posedge clock);
    `CHK(spinIndicator, 1'b0)
    cmd(K_KCW);
    cmd(K_KSTOP);
    `CHK(spinIndicator, 1'b0)
    cmd(K_KSTOP);
    `CHK(jogActive, 1'b0)
    wr(A_JOG, 32'h0);
    cmd(K_KSTOP);
    `CHK(jogActive, 1'b0)
  endtask

  task automatic t_pulse();
    wr(A_CTRL, ctrl(3'd4, 6'h04));
    cmd(K_TCW);
    `CHK(spinCw, 1'b1)
    repeat (4 * TICK) @(posedge clock);
    `CHK(spinCw, 1'b0)
    `CHK(spinIndicator, 1'b1)
    cmd(K_TSTOP);
    `CHK(spinStop, 1'b1)
    `CHK(spindleBrakeOut, 1'b1)
    repeat (4 * TICK) @(posedge clock);
    `CHK(spinStop, 1'b0)
    wr(A_CTRL, ctrl(3'd4, 6'h00));
  endtask

  task automatic t_gear_fixed();
    logic [3:0] e;
    for (int v = 0; v < 6; v++) begin
      cmd(gear(4'(v)));
      e = (v == 0) ? 4'h0 : (v == 5) ? 4'h8 : 4'h1 << (v - 1);
      `CHK(gearLines, e)
    end
    wr(A_CTRL, ctrl(3'd4, 6'h10));
    for (int v = 0; v < 16; v++) begin
      cmd(gear(4'(v)));
      `CHK(gearLines, 4'(v))
    end
    wr(A_CTRL, ctrl(3'd2, 6'h10));
    cmd(gear(4'hd));
    `CHK(gearLines, 4'h1)
    `CHK(gearLineOe, 4'h3)
    wr(A_CTRL, ctrl(3'd0, 6'h10));
    cmd(gear(4'hf));
    `CHK(gearLineOe, 4'h0)
  endtask

  task automatic t_shift(input logic [3:0] v, input logic [3:0] e,
                         input ssg_mv_type mx, input logic [7:0] hold);
    int i;
    holdCycles <= hold;
    cmd(gear(v));
    `CHK(shiftBusy, 1'b1)
    `CHK(analogMv, 14'h04d2)
    for (i = 0; i < 100 && gearLines !== 4'h0; i++) @(posedge clock);
    `CHK(gearLines, 4'h0)
    for (i = 0; i < 100 && gearLines !== e; i++) @(posedge clock);
    `CHK(i > 3, 1'b1)
    `CHK(gearLines, e)
    repeat (30) @(posedge clock);
    `CHK(shiftBusy, hold > 8'd40)
    for (i = 0; i < 200 && shiftBusy !== 1'b0; i++) @(posedge clock);
    `CHK(analogMv, mx)
    `CHK(currentGear, 2'(v - 4'd1))
  endtask

  task automatic t_gear_vf();
    wr(A_SHT, 32'h00020202);
    wr(A_SHV, 32'h000004d2);
    wr(A_M12, 32'h13880fa0);
    wr(A_M34, 32'h00001770);
    wr(A_CTRL, ctrl(3'd4, 6'h28));
    t_shift(4'd2, 4'h2, 14'h1388, 8'd60);
    t_shift(4'd3, 4'h4, 14'h1770, 8'd2);
    cmd(gear(4'd3));
    `CHK(shiftBusy, 1'b0)
    `CHK(analogMv, 14'h1770)
  endtask

  task automatic t_memory();
    rst_n <= 1'b0;
    gearMemoryEnable <= 1'b1;
    retainedGear <= 2'd2;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    `CHK(currentGear, 2'd2)
    `CHK(gearLines, 4'h0)
  endtask

  task automatic close_out();
    if (n_errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    t_reset();
    t_run();
    t_chuck();
    t_jog();
    t_pulse();
    t_gear_fixed();
    t_gear_vf();
    t_memory();
    close_out();
  end
endmodule // ssg_spindle_gear_tb
